// ### hw/flis_capture.sv
// Last-instruction pointer and opcode capture with save/restore paths and APB access.
`timescale 1ns/100ps
`default_nettype none
`include "flis_params.svh"
module flis_capture
  import flis_pkg::*;
(
  // Clock and reset.
  input  wire logic                   clk,
  input  wire logic                   reset,
  // APB slave.
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`FLIS_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  // Retire strobe from the pipeline.
  input  wire logic                   ret_valid,
  input  wire logic                   ret_control,
  input  wire logic                   ret_has_mem,
  input  wire logic [`FLIS_OFF_W-1:0] ret_ip_off,
  input  wire logic [`FLIS_SEL_W-1:0] ret_ip_sel,
  input  wire logic [`FLIS_OFF_W-1:0] ret_op_off,
  input  wire logic [`FLIS_SEL_W-1:0] ret_op_sel,
  input  wire logic [7:0]             ret_opc1,
  input  wire logic [7:0]             ret_opc2,
  input  wire logic                   ret_unmasked_exc,
  // Save, restore and initialize commands.
  input  wire logic                   cmd_valid,
  input  wire flis_cmd_t              cmd_kind,
  input  wire logic                   protection_enable,
  input  wire logic                   long_mode_64,
  input  wire logic                   wide_operand_prefix,
  input  wire logic                   v86_mode,
  input  wire logic                   system_management_mode,
  input  wire logic                   operand_size32,
  input  wire logic [`FLIS_OFF_W-1:0] mem_ip_off,
  input  wire logic [`FLIS_SEL_W-1:0] mem_ip_sel,
  input  wire logic [`FLIS_OFF_W-1:0] mem_op_off,
  input  wire logic [`FLIS_SEL_W-1:0] mem_op_sel,
  input  wire logic [`FLIS_OPC_W-1:0] mem_opcode,
  // Store image towards memory.
  output logic                        st_valid,
  output logic [`FLIS_OFF_W-1:0]      st_ip_off,
  output logic [`FLIS_SEL_W-1:0]      st_ip_sel,
  output logic [`FLIS_OFF_W-1:0]      st_op_off,
  output logic [`FLIS_SEL_W-1:0]      st_op_sel,
  output logic                        st_sel_valid,
  output logic [`FLIS_OPC_W-1:0]      st_opcode,
  output logic                        st_opcode_valid,
  output logic                        st_data_regs,
  output logic                        st_vector,
  output flis_layout_t                st_layout,
  // Load and initialize notices to the rest of the unit.
  output logic                        ld_valid,
  output logic                        ld_data_regs,
  output logic                        ld_vector,
  output logic                        init_pulse,
  output logic [15:0]                 init_control_word,
  output logic [15:0]                 init_tag_word
);

  ////////////////////////////////////////////////////////////////////////////////
  flis_state_t s;
  flis_state_t next_s;
  logic        mapped;
  logic        wide;
  logic        prot;

  // Only the eight register words decode; any other offset answers with an error.
  always_comb begin
    case (paddr)
      `FLIS_CTRL_ADDR, `FLIS_IPLO_ADDR, `FLIS_IPHI_ADDR, `FLIS_IPSEL_ADDR,
      `FLIS_OPLO_ADDR, `FLIS_OPHI_ADDR, `FLIS_OPSEL_ADDR, `FLIS_OPC_ADDR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Zero wait states: every access completes in its first access cycle.
  assign pready  = psel & penable;
  assign pslverr = psel & penable & ~mapped;
  assign wide    = long_mode_64 & wide_operand_prefix;
  // Virtual-8086 and system management mode both fall back to the real-mode image.
  assign prot    = protection_enable & ~v86_mode & ~system_management_mode;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s            = s;
    next_s.st_valid   = 1'b0;
    next_s.ld_valid   = 1'b0;
    next_s.init_pulse = 1'b0;
    // Read data is latched in the setup cycle so that it comes from a flop.
    if (psel && !penable && !pwrite) begin
      case (paddr)
        `FLIS_CTRL_ADDR:  next_s.prdata = 32'(s.compat) << `FLIS_COMPAT_BIT;
        `FLIS_IPLO_ADDR:  next_s.prdata = s.ip_off[31:0];
        `FLIS_IPHI_ADDR:  next_s.prdata = s.ip_off[63:32];
        `FLIS_IPSEL_ADDR: next_s.prdata = {16'h0000, s.ip_sel};
        `FLIS_OPLO_ADDR:  next_s.prdata = s.op_off[31:0];
        `FLIS_OPHI_ADDR:  next_s.prdata = s.op_off[63:32];
        `FLIS_OPSEL_ADDR: next_s.prdata = {16'h0000, s.op_sel};
        `FLIS_OPC_ADDR:   next_s.prdata = (32'(s.exc) << `FLIS_EXC_BIT) | 32'(s.opcode);
        default:          next_s.prdata = 32'h0000_0000;
      endcase
    end
    if (psel && penable && pwrite && paddr == `FLIS_CTRL_ADDR) begin
      next_s.compat = pwdata[`FLIS_COMPAT_BIT];
    end
    // A state command wins over a retire in the same cycle; the pipeline never overlaps them.
    if (cmd_valid) begin
      case (cmd_kind)
        FLIS_INIT: begin
          next_s.ip_off     = '0;
          next_s.ip_sel     = '0;
          next_s.op_off     = '0;
          next_s.op_sel     = '0;
          next_s.init_pulse = 1'b1;
        end
        // Legacy loads use the raw protection bit, not the layout-adjusted one.
        FLIS_LDENV, FLIS_RSTOR: begin
          next_s.ip_off       = {32'h0000_0000, mem_ip_off[31:0]};
          next_s.op_off       = {32'h0000_0000, mem_op_off[31:0]};
          next_s.ip_sel       = protection_enable ? mem_ip_sel : '0;
          next_s.op_sel       = protection_enable ? mem_op_sel : '0;
          next_s.opcode       = mem_opcode;
          next_s.ld_valid     = 1'b1;
          next_s.ld_data_regs = (cmd_kind == FLIS_RSTOR);
          next_s.ld_vector    = 1'b0;
        end
        // Selectors always travel with the image; st_sel_valid says whether memory keeps them.
        FLIS_STENV, FLIS_SAVE: begin
          next_s.st_valid        = 1'b1;
          next_s.st_ip_off       = {32'h0000_0000, s.ip_off[31:0]};
          next_s.st_op_off       = {32'h0000_0000, s.op_off[31:0]};
          next_s.st_ip_sel       = s.ip_sel;
          next_s.st_op_sel       = s.op_sel;
          next_s.st_sel_valid    = protection_enable;
          next_s.st_opcode       = s.opcode;
          next_s.st_opcode_valid = s.compat | s.exc;
          next_s.st_data_regs    = (cmd_kind == FLIS_SAVE);
          next_s.st_vector       = 1'b0;
          next_s.st_layout       = prot ? (operand_size32 ? FLIS_PROT32 : FLIS_PROT16)
                                        : (operand_size32 ? FLIS_REAL32 : FLIS_REAL16);
          if (cmd_kind == FLIS_SAVE) begin
            next_s.ip_off     = '0;
            next_s.ip_sel     = '0;
            next_s.op_off     = '0;
            next_s.op_sel     = '0;
            next_s.init_pulse = 1'b1;
          end
        end
        // Only the wide form carries whole offsets; it then drops the selectors.
        FLIS_XRESTORE: begin
          next_s.ip_off       = wide ? mem_ip_off : {32'h0000_0000, mem_ip_off[31:0]};
          next_s.op_off       = wide ? mem_op_off : {32'h0000_0000, mem_op_off[31:0]};
          next_s.ip_sel       = wide ? '0 : mem_ip_sel;
          next_s.op_sel       = wide ? '0 : mem_op_sel;
          next_s.opcode       = mem_opcode;
          next_s.ld_valid     = 1'b1;
          next_s.ld_data_regs = 1'b1;
          next_s.ld_vector    = 1'b1;
        end
        FLIS_XSTORE: begin
          next_s.st_valid        = 1'b1;
          next_s.st_ip_off       = wide ? s.ip_off : {32'h0000_0000, s.ip_off[31:0]};
          next_s.st_op_off       = wide ? s.op_off : {32'h0000_0000, s.op_off[31:0]};
          next_s.st_ip_sel       = s.ip_sel;
          next_s.st_op_sel       = s.op_sel;
          next_s.st_sel_valid    = ~wide;
          next_s.st_opcode       = s.opcode;
          next_s.st_opcode_valid = s.compat | s.exc;
          next_s.st_data_regs    = 1'b1;
          next_s.st_vector       = 1'b1;
          // The extended image has a single layout, so the legacy layout code is fixed.
          next_s.st_layout       = FLIS_PROT32;
        end
        default: begin
        end
      endcase
    end else if (ret_valid && !ret_control) begin
      // The pipeline hands over the address of the first prefix byte, not the opcode byte.
      next_s.ip_off = ret_ip_off;
      next_s.ip_sel = ret_ip_sel;
      next_s.opcode = {ret_opc1[2:0], ret_opc2};
      next_s.exc    = ret_unmasked_exc;
      // No memory operand leaves the old operand pointer, which is then meaningless.
      if (ret_has_mem) begin
        next_s.op_off = ret_op_off;
        next_s.op_sel = ret_op_sel;
      end
    end
  end

  // Pulses and read data live in the same struct, so reset clears them together.
  always_ff @(posedge clk) begin
    if (reset) begin
      s           <= '0;
      s.st_layout <= FLIS_PROT32;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Every output except pready, pslverr and the two initialize words is a direct copy of a state flop.
  assign prdata            = s.prdata;
  assign st_valid          = s.st_valid;
  assign st_ip_off         = s.st_ip_off;
  assign st_ip_sel         = s.st_ip_sel;
  assign st_op_off         = s.st_op_off;
  assign st_op_sel         = s.st_op_sel;
  assign st_sel_valid      = s.st_sel_valid;
  assign st_opcode         = s.st_opcode;
  assign st_opcode_valid   = s.st_opcode_valid;
  assign st_data_regs      = s.st_data_regs;
  assign st_vector         = s.st_vector;
  assign st_layout         = s.st_layout;
  assign ld_valid          = s.ld_valid;
  assign ld_data_regs      = s.ld_data_regs;
  assign ld_vector         = s.ld_vector;
  assign init_pulse        = s.init_pulse;
  assign init_control_word = `FLIS_CW_INIT;
  assign init_tag_word     = `FLIS_TW_INIT;

  ////////////////////////////////////////////////////////////////////////////////
  // The checks below sample on the block clock and stand idle during reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic ncmd;
  assign ncmd = ~cmd_valid;

  retire_capture_a: assert property (ret_valid && !ret_control && ncmd |=>
    s.ip_off == $past(ret_ip_off) && s.ip_sel == $past(ret_ip_sel))
    else $error("retired instruction address not captured");
  control_hold_a: assert property (ret_valid && ret_control && ncmd |=>
    $stable(s.ip_off) && $stable(s.op_off) && $stable(s.opcode))
    else $error("control instruction changed pointers");
  init_clear_a: assert property (cmd_valid && cmd_kind == FLIS_INIT |=>
    s.ip_off == '0 && s.op_off == '0 && s.ip_sel == '0 && s.op_sel == '0 && init_pulse)
    else $error("initialize did not clear pointers");
  legacy_load_a: assert property (cmd_valid && (cmd_kind == FLIS_LDENV ||
    cmd_kind == FLIS_RSTOR) |=>
    s.ip_off[63:32] == 32'h0000_0000 &&
    s.op_off[63:32] == 32'h0000_0000 &&
    s.ip_sel == ($past(protection_enable) ? $past(mem_ip_sel) : 16'h0000))
    else $error("legacy load mishandled offset or selector");
  save_clear_a: assert property (cmd_valid && cmd_kind == FLIS_SAVE |=>
    st_valid && st_ip_off == {32'h0000_0000, $past(s.ip_off[31:0])} && s.ip_off == '0
    && init_pulse ##1 (!st_valid || $past(cmd_valid)))
    else $error("full save did not store then clear");
  xrest_wide_a: assert property (cmd_valid && cmd_kind == FLIS_XRESTORE && wide |=>
    s.op_off == $past(mem_op_off) && s.op_sel == '0 && ld_vector)
    else $error("wide extended restore wrong");
  xstore_narrow_a: assert property (cmd_valid && cmd_kind == FLIS_XSTORE && !wide |=>
    st_sel_valid && st_op_off[63:32] == 32'h0000_0000 && st_vector)
    else $error("narrow extended save wrong");
  opcode_pack_a: assert property (ret_valid && !ret_control && ncmd |=>
    s.opcode == {$past(ret_opc1[2:0]), $past(ret_opc2)})
    else $error("opcode packing wrong");
  opcode_valid_a: assert property (cmd_valid && cmd_kind == FLIS_STENV |=>
    st_opcode_valid == ($past(s.compat) || $past(s.exc)))
    else $error("opcode valid flag wrong");
  apb_read_a: assert property (psel && !penable && !pwrite && paddr == `FLIS_IPLO_ADDR |=>
    prdata == $past(s.ip_off[31:0]))
    else $error("pointer read data wrong");
  // Without a memory operand the old operand pointer must survive the retire.
  op_hold_a: assert property (ret_valid && !ret_control && !ret_has_mem && ncmd |=>
    $stable(s.op_off) &&
    $stable(s.op_sel))
    else $error("operand pointer changed without a memory operand");
  legacy_store_a: assert property (cmd_valid && cmd_kind == FLIS_STENV |=>
    st_valid &&
    st_op_off[63:32] == 32'h0000_0000 &&
    st_op_off[31:0] == $past(s.op_off[31:0]) &&
    st_sel_valid == $past(protection_enable))
    else $error("legacy store image wrong");
  xrest_narrow_a: assert property (cmd_valid && cmd_kind == FLIS_XRESTORE && !wide |=>
    s.ip_off[63:32] == 32'h0000_0000 &&
    s.ip_off[31:0] == $past(mem_ip_off[31:0]) &&
    s.ip_sel == $past(mem_ip_sel))
    else $error("narrow extended restore wrong");
  xstore_wide_a: assert property (cmd_valid && cmd_kind == FLIS_XSTORE && wide |=>
    st_ip_off == $past(s.ip_off) &&
    st_op_off == $past(s.op_off) &&
    !st_sel_valid)
    else $error("wide extended save wrong");
  compat_write_a: assert property (pready && pwrite && paddr == `FLIS_CTRL_ADDR |=>
    s.compat == $past(pwdata[`FLIS_COMPAT_BIT]))
    else $error("compatibility bit not written");
  // Virtual-8086 mode must fall back to a real-mode image even when protected.
  layout_real_a: assert property (cmd_valid && cmd_kind == FLIS_STENV && v86_mode |=>
    st_layout == ($past(operand_size32) ? FLIS_REAL32 : FLIS_REAL16))
    else $error("legacy layout wrong in virtual-8086 mode");
  ld_pulse_a: assert property (cmd_valid && cmd_kind == FLIS_LDENV |=>
    ld_valid && !ld_data_regs && !ld_vector ##1
    (!ld_valid || $past(cmd_valid)))
    else $error("environment load notice wrong");
  init_words_a: assert property (init_pulse |->
    init_control_word == 16'h037f &&
    init_tag_word == 16'hffff)
    else $error("initial control or tag word wrong");

  save_seen_c: cover property (cmd_valid && cmd_kind == FLIS_SAVE ##1 st_valid);
  retire_then_save_c: cover property (ret_valid && !ret_control ##2 cmd_valid
    && cmd_kind == FLIS_STENV);
  compat_set_c: cover property (s.compat && st_valid);
  wide_restore_c: cover property (cmd_valid && cmd_kind == FLIS_XRESTORE && wide ##1 ld_vector);

endmodule : flis_capture
`default_nettype wire

// ### hw/flis_params.svh
// Constants for the floating-point last-instruction state capture block.
//
// How it works
// - A retiring non-control instruction records its instruction and operand addresses.
// - Without a memory operand the operand pointer holds its previous value.
// - Control instructions leave both pointers untouched.
// - The captured instruction address is that of the first prefix byte.
// - Each pointer is a 64-bit offset plus a 16-bit selector.
// - Initialize clears both offsets and both selectors.
// - Legacy load zeroes upper offset halves; selectors load only when protected.
// - Legacy store gives low offset halves; selectors valid only when protected.
// - Legacy full save clears offsets and selectors after storing them.
// - Extended restore: wide form loads full offsets, clears selectors; else narrow.
// - Extended save: wide form stores full offsets without selectors; else narrow.
// - Opcode keeps low three bits of byte one plus byte two.
// - Bit 2 of the misc enable register selects opcode compatibility mode.
// - With compatibility on, the stored opcode is always valid.
// - With compatibility off, opcode valid only after an unmasked exception.
// - Environment store includes words, pointers, opcode; full save adds data registers.
// - A legacy full save reinitializes the unit after storing.
// - Legacy layout follows protection and operand size; v86 and system management use real.
// - Environment load restores words, pointers, opcode; full restore adds data registers.
// - Extended save and restore also move vector registers and vector control.
// - Initialize sets the control word to 037f.
// - Initialize sets the tag word to ffff.
`ifndef FLIS_PARAMS_SVH
`define FLIS_PARAMS_SVH

`define FLIS_OFF_W       64
`define FLIS_SEL_W       16
`define FLIS_OPC_W       11
`define FLIS_ADDR_W      12
`define FLIS_CTRL_ADDR   12'h000
`define FLIS_IPLO_ADDR   12'h004
`define FLIS_IPHI_ADDR   12'h008
`define FLIS_IPSEL_ADDR  12'h00c
`define FLIS_OPLO_ADDR   12'h010
`define FLIS_OPHI_ADDR   12'h014
`define FLIS_OPSEL_ADDR  12'h018
`define FLIS_OPC_ADDR    12'h01c
`define FLIS_COMPAT_BIT  2
`define FLIS_EXC_BIT     16
`define FLIS_CW_INIT     16'h037f
`define FLIS_TW_INIT     16'hffff

`endif

// ### hw/flis_pkg.sv
// Types for the floating-point last-instruction state capture block.
`include "flis_params.svh"
package flis_pkg;
  typedef enum logic [2:0] {
    FLIS_INIT, FLIS_LDENV, FLIS_RSTOR, FLIS_STENV, FLIS_SAVE, FLIS_XRESTORE, FLIS_XSTORE
  } flis_cmd_t;

  typedef enum logic [1:0] {FLIS_PROT32, FLIS_PROT16, FLIS_REAL32, FLIS_REAL16} flis_layout_t;

  typedef struct packed {
    logic [`FLIS_OFF_W-1:0] ip_off;
    logic [`FLIS_SEL_W-1:0] ip_sel;
    logic [`FLIS_OFF_W-1:0] op_off;
    logic [`FLIS_SEL_W-1:0] op_sel;
    logic [`FLIS_OPC_W-1:0] opcode;
    logic                   exc;
    logic                   compat;
    logic [31:0]            prdata;
    logic                   st_valid;
    logic [`FLIS_OFF_W-1:0] st_ip_off;
    logic [`FLIS_SEL_W-1:0] st_ip_sel;
    logic [`FLIS_OFF_W-1:0] st_op_off;
    logic [`FLIS_SEL_W-1:0] st_op_sel;
    logic                   st_sel_valid;
    logic [`FLIS_OPC_W-1:0] st_opcode;
    logic                   st_opcode_valid;
    logic                   st_data_regs;
    logic                   st_vector;
    flis_layout_t           st_layout;
    logic                   ld_valid;
    logic                   ld_data_regs;
    logic                   ld_vector;
    logic                   init_pulse;
  } flis_state_t;
endpackage : flis_pkg

// ### bench/flis_mem_model.sv
// Memory-side model that keeps the last stored state image and offers it to loads.
`timescale 1ns/100ps
`default_nettype none
module flis_mem_model #(
  parameter logic [63:0] INIT_IP = 64'hc3c3_0000_1357_2468,
  parameter logic [63:0] INIT_OP = 64'h5a5a_0000_8642_7531
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        st_valid,
  input  wire logic        st_vector,
  input  wire logic        st_sel_valid,
  input  wire logic [63:0] st_ip_off,
  input  wire logic [15:0] st_ip_sel,
  input  wire logic [63:0] st_op_off,
  input  wire logic [15:0] st_op_sel,
  output logic      [63:0] mem_ip_off,
  output logic      [15:0] mem_ip_sel,
  output logic      [63:0] mem_op_off,
  output logic      [15:0] mem_op_sel
);
  // Only an extended image without selectors carries whole offsets.
  logic wide;
  assign wide = st_vector & ~st_sel_valid;
  always_ff @(posedge clk) begin
    if (reset) begin
      mem_ip_off <= INIT_IP;
      mem_op_off <= INIT_OP;
      mem_ip_sel <= 16'h0a51;
      mem_op_sel <= 16'h0b62;
    end else if (st_valid) begin
      // Upper halves are not in a narrow image, so show an inverse pattern there.
      mem_ip_off <= wide ? st_ip_off : {~st_ip_off[31:0], st_ip_off[31:0]};
      mem_op_off <= wide ? st_op_off : {~st_op_off[31:0], st_op_off[31:0]};
      if (st_sel_valid) begin
        mem_ip_sel <= st_ip_sel;
        mem_op_sel <= st_op_sel;
      end
    end
  end
endmodule : flis_mem_model
`default_nettype wire

// ### bench/fpu_last_instr_state_capture_bench.sv
// Self-checking bench for the last-instruction state capture block.
`timescale 1ns/100ps
`default_nettype none
`include "flis_params.svh"
module fpu_last_instr_state_capture_bench;
  import flis_pkg::*;
  localparam logic [5:0]  PROT32 = 6'b100001;
  localparam logic [5:0]  REAL32 = 6'b000001;
  localparam logic [5:0]  WIDE   = 6'b111001;
  localparam logic [5:0]  NARROW = 6'b110001;
  localparam logic [63:0] A      = 64'h8000_0001_0000_0f00;
  localparam logic [63:0] B      = 64'h7fff_fffe_ffff_f0f0;
  localparam logic [63:0] IP0    = 64'hc3c3_0000_1357_2468;
  localparam logic [63:0] OP0    = 64'h5a5a_0000_8642_7531;
  localparam logic [5:0]  LAY [4] = '{PROT32, 6'b100000, 6'b100011, 6'b100100};
  logic clk, reset, psel, penable, pwrite, pready, pslverr, ret_valid, ret_control, ret_has_mem;
  logic ret_unmasked_exc, cmd_valid, protection_enable, long_mode_64, wide_operand_prefix;
  logic v86_mode, system_management_mode, operand_size32, st_valid, st_sel_valid, st_opcode_valid;
  logic st_data_regs, st_vector, ld_valid, ld_data_regs, ld_vector, init_pulse, err, p_st, p_ld, p_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [63:0] ret_ip_off, ret_op_off, mem_ip_off, mem_op_off, st_ip_off, st_op_off;
  logic [15:0] ret_ip_sel, ret_op_sel, mem_ip_sel, mem_op_sel, st_ip_sel, st_op_sel;
  logic [15:0] init_control_word, init_tag_word;
  logic [10:0] mem_opcode, st_opcode;
  logic [7:0]  ret_opc1, ret_opc2;
  flis_cmd_t    cmd_kind;
  flis_layout_t st_layout;
  int error_cnt = 0;
  int tests_run = 0;

  flis_capture DUT (
    .clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .ret_valid, .ret_control, .ret_has_mem, .ret_ip_off, .ret_ip_sel, .ret_op_off, .ret_op_sel,
    .ret_opc1, .ret_opc2, .ret_unmasked_exc, .cmd_valid, .cmd_kind, .protection_enable,
    .long_mode_64, .wide_operand_prefix, .v86_mode, .system_management_mode, .operand_size32,
    .mem_ip_off, .mem_ip_sel, .mem_op_off, .mem_op_sel, .mem_opcode, .st_valid, .st_ip_off,
    .st_ip_sel, .st_op_off, .st_op_sel, .st_sel_valid, .st_opcode, .st_opcode_valid,
    .st_data_regs, .st_vector, .st_layout, .ld_valid, .ld_data_regs, .ld_vector, .init_pulse,
    .init_control_word, .init_tag_word
  );
  flis_mem_model MEM (
    .clk, .reset, .st_valid, .st_vector, .st_sel_valid, .st_ip_off, .st_ip_sel, .st_op_off,
    .st_op_sel, .mem_ip_off, .mem_ip_sel, .mem_op_off, .mem_op_sel
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input string nm, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(nm, {32'h0, e & m}, {32'h0, q & m});
  endtask : rd

  task automatic chk_ptr(input logic [63:0] ip, input logic [15:0] is, input logic [63:0] op,
                         input logic [15:0] os);
    rd(`FLIS_IPLO_ADDR, "ip_lo", ip[31:0], 32'hffff_ffff);
    rd(`FLIS_IPHI_ADDR, "ip_hi", ip[63:32], 32'hffff_ffff);
    rd(`FLIS_IPSEL_ADDR, "ip_sel", {16'h0, is}, 32'h0000_ffff);
    rd(`FLIS_OPLO_ADDR, "op_lo", op[31:0], 32'hffff_ffff);
    rd(`FLIS_OPHI_ADDR, "op_hi", op[63:32], 32'hffff_ffff);
    rd(`FLIS_OPSEL_ADDR, "op_sel", {16'h0, os}, 32'h0000_ffff);
  endtask : chk_ptr

  task automatic retire(input logic ctl, input logic exc, input logic [63:0] ip, input logic [63:0] op);
    @(posedge clk);
    ret_valid <= 1'b1;
    ret_control <= ctl;
    ret_has_mem <= (op != 64'h0);
    ret_unmasked_exc <= exc;
    ret_ip_off <= ip;
    ret_ip_sel <= ~ip[15:0];
    ret_op_off <= op;
    ret_op_sel <= ~op[15:0];
    ret_opc1 <= 8'hdd;
    ret_opc2 <= 8'hc1;
    @(posedge clk);
    ret_valid <= 1'b0;
  endtask : retire

  // Pulses are sampled one step after the taking edge itself.
  task automatic cmd(input flis_cmd_t k, input logic [5:0] m);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    {protection_enable, long_mode_64, wide_operand_prefix, v86_mode,
     system_management_mode, operand_size32} <= m;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    p_st = st_valid;
    p_ld = ld_valid;
    p_in = init_pulse;
  endtask : cmd

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (4000) @(posedge clk);
    error_cnt++;
    stop_test();
  end

  initial begin
    {psel, penable, pwrite, ret_valid, ret_control, ret_has_mem, ret_unmasked_exc, cmd_valid} = '0;
    {protection_enable, long_mode_64, wide_operand_prefix, v86_mode} = '0;
    {system_management_mode, operand_size32, paddr, pwdata} = '0;
    {ret_ip_off, ret_op_off, ret_ip_sel, ret_op_sel, ret_opc1, ret_opc2} = '0;
    cmd_kind = FLIS_INIT;
    mem_opcode = 11'h2a5;
    reset = 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    chk_ptr(64'h0, 16'h0, 64'h0, 16'h0);
    retire(1'b0, 1'b0, A, B);
    chk_ptr(A, ~A[15:0], B, ~B[15:0]);
    rd(`FLIS_OPC_ADDR, "opcode", 32'h5c1, 32'h7ff);
    // Control retire leaves ~A and ~B on the lines afterwards, while the strobe is low.
    retire(1'b1, 1'b0, ~A, ~B);
    chk_ptr(A, ~A[15:0], B, ~B[15:0]);
    retire(1'b0, 1'b0, ~A, 64'h0);
    chk_ptr(~A, A[15:0], B, ~B[15:0]);
    cmd(FLIS_LDENV, PROT32);
    chk("ld_pulse", 1, p_ld);
    chk_ptr({32'h0, IP0[31:0]}, 16'h0a51, {32'h0, OP0[31:0]}, 16'h0b62);
    rd(`FLIS_OPC_ADDR, "opcode_ld", 32'h2a5, 32'h7ff);
    cmd(FLIS_RSTOR, REAL32);
    chk("ld_data_regs", 1, ld_data_regs);
    chk_ptr({32'h0, IP0[31:0]}, 16'h0, {32'h0, OP0[31:0]}, 16'h0);
    retire(1'b0, 1'b0, A, B);
    cmd(FLIS_STENV, PROT32);
    chk("st_pulse", 1, p_st);
    chk("st_ip_off", {32'h0, A[31:0]}, st_ip_off);
    chk("st_op_off", {32'h0, B[31:0]}, st_op_off);
    chk("st_sel_valid", 1, st_sel_valid);
    chk("st_ip_sel", {48'h0, ~A[15:0]}, st_ip_sel);
    chk("st_op_sel", {48'h0, ~B[15:0]}, st_op_sel);
    chk("st_data_regs", 0, st_data_regs);
    chk("st_opcode_valid", 0, st_opcode_valid);
    chk_ptr(A, ~A[15:0], B, ~B[15:0]);
    cmd(FLIS_SAVE, 6'b000000);
    chk("init_pulse", 1, p_in);
    chk("st_sel_valid", 0, st_sel_valid);
    chk("st_data_regs", 1, st_data_regs);
    chk("st_layout", 3, st_layout);
    chk("control_word", 16'h037f, init_control_word);
    chk("tag_word", 16'hffff, init_tag_word);
    chk_ptr(64'h0, 16'h0, 64'h0, 16'h0);
    cmd(FLIS_LDENV, PROT32);
    chk_ptr({32'h0, A[31:0]}, ~A[15:0], {32'h0, B[31:0]}, ~B[15:0]);
    cmd(FLIS_XRESTORE, WIDE);
    chk("ld_vector", 1, ld_vector);
    chk_ptr({~A[31:0], A[31:0]}, 16'h0, {~B[31:0], B[31:0]}, 16'h0);
    retire(1'b0, 1'b1, A, B);
    cmd(FLIS_XSTORE, WIDE);
    chk("st_ip_off", A, st_ip_off);
    chk("st_op_off", B, st_op_off);
    chk("st_sel_valid", 0, st_sel_valid);
    chk("st_vector", 1, st_vector);
    chk("st_opcode_valid", 1, st_opcode_valid);
    chk("st_opcode", 11'h5c1, st_opcode);
    cmd(FLIS_XRESTORE, NARROW);
    chk_ptr({32'h0, A[31:0]}, ~A[15:0], {32'h0, B[31:0]}, ~B[15:0]);
    cmd(FLIS_XSTORE, NARROW);
    chk("st_sel_valid", 1, st_sel_valid);
    chk("st_op_sel", {48'h0, ~B[15:0]}, st_op_sel);
    apb(1'b1, `FLIS_CTRL_ADDR, 32'h4);
    rd(`FLIS_CTRL_ADDR, "compat", 32'h4, 32'h4);
    retire(1'b0, 1'b0, A, B);
    cmd(FLIS_STENV, PROT32);
    chk("st_opcode_valid", 1, st_opcode_valid);
    cmd(FLIS_INIT, PROT32);
    chk("init_pulse", 1, p_in);
    chk_ptr(64'h0, 16'h0, 64'h0, 16'h0);
    for (int i = 0; i < 4; i++) begin
      cmd(FLIS_STENV, LAY[i]);
      chk("st_layout", i, st_layout);
    end
    apb(1'b0, 12'h0f0, 32'h0);
    chk("pslverr", 1, err);
    chk("unmapped", 0, q);
    stop_test();
  end
endmodule : fpu_last_instr_state_capture_bench
`default_nettype wire
